// >>> rtl/psm_pkg.sv
package psm_pkg;

    // ==================================================
    // Register map (byte addresses, one word each)
    // ==================================================
    localparam logic [7:0] ADDR_CLOCK_DIVISOR = 8'h00;
    localparam logic [7:0] ADDR_RESET_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_MODULE_DISABLE = 8'h08;
    localparam logic [7:0] ADDR_POWER_SAVE = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;

    // clock_divisor_reg fields
    localparam int RATIO_LSB = 12;
    localparam int SLOWDOWN_EN_BIT = 11;
    localparam int RECOVER_BIT = 15;
    localparam logic [2:0] RATIO_RESET = 3'h0;

    // reset_control_reg fields
    localparam int CORE_REG_STBY_BIT = 8;
    localparam int FLASH_REG_STBY_BIT = 11;

    // capture_compare_module_disable fields and write mask
    localparam int CAPTURE_LSB = 8;
    localparam int COMPARE_LSB = 0;
    localparam logic [15:0] MODULE_DISABLE_MASK = 16'h0F0F;
    localparam logic [15:0] MODULE_DISABLE_RESET = 16'h0000;

    // power_save_instruction operand values
    localparam logic [1:0] OPERAND_SLEEP = 2'h0;
    localparam logic [1:0] OPERAND_IDLE = 2'h1;

    // Resume delay after Idle wake, in cycles of clk_sys (2 to 4 allowed)
    localparam logic [2:0] IDLE_RESUME_CYCLES = 3'h3;

    typedef enum {
        PSM_RUN,
        PSM_ENTER,
        PSM_SLEEP,
        PSM_IDLE,
        PSM_RESUME
    } psm_state_type;

    // Clock and power controls handed to the clock tree
    typedef struct packed {
        logic sys_clk_run;
        logic onchip_osc_run;
        logic low_power_rc_osc_run;
        logic monitor_active;
        logic core_reg_standby;
        logic flash_reg_standby;
        logic cpu_clk_run;
        logic sysclk_periph_run;
        logic wdt_clear;
    } psm_power_ctl_type;

endpackage

// >>> rtl/psm_power_save_ctl.sv
`timescale 1ns/10ps
// Notes on behaviour
// [R01] Ratio writes ignored while slowdown enabled
// [R02] Slowdown enable refused when ratio is zero
// [R03] Interrupt clears slowdown when recover bit set
// [R04] Sleep stops system clock and on-chip oscillator
// [R05] Clock fail monitor inactive in Sleep
// [R06] Low-power RC runs in Sleep with watchdog
// [R07] Watchdog cleared before Sleep entry
// [R08] Sleep halts system-clocked peripherals only
// [R09] Sleep exits on interrupt, reset, watchdog
// [R10] Sleep wake resumes on previous clock source
// [R11] Regulator bits clear mean standby in Sleep
// [R12] Idle stops CPU, clears watchdog, clock runs
// [R13] Low-power RC runs in Idle with watchdog/monitor
// [R14] Idle exits on interrupt, reset, watchdog
// [R15] Idle wake resumes CPU 2-4 cycles later
// [R16] Per-peripheral stop-in-idle control honoured
// [R17] Interrupt during instruction held until entry done
// [R18] Bits 11..8 disable capture channels 4..1
// [R19] Bits 3..0 disable compare channels 4..1
// [R20] Processor picks Sleep or Idle by operand
module psm_power_save_ctl #(
    parameter int PERIPH_COUNT = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Core side
    input wire logic interrupt_pending,
    input wire logic wdt_timeout,
    input wire logic wdt_enabled,
    input wire logic monitor_enabled,
    input wire logic [PERIPH_COUNT-1:0] periph_stop_in_idle,
    output psm_pkg::psm_power_ctl_type power_ctl,
    output logic [2:0] cpu_slowdown_ratio,
    output logic slowdown_active,
    output logic [PERIPH_COUNT-1:0] periph_run,
    output logic [3:0] capture_off,
    output logic [3:0] compare_off,
    output logic cpu_resumed
);

    // ==================================================
    // Bus decode
    // ==================================================
    wire logic bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire logic bus_wr = bus_req & wb_we_i;
    wire logic sel_lo = wb_sel_i[0];
    wire logic sel_hi = wb_sel_i[1];
    wire logic hit_div = wb_adr_i == psm_pkg::ADDR_CLOCK_DIVISOR;
    wire logic hit_reset_control_reg = wb_adr_i == psm_pkg::ADDR_RESET_CONTROL;
    wire logic hit_pmd = wb_adr_i == psm_pkg::ADDR_MODULE_DISABLE;
    wire logic hit_pws = wb_adr_i == psm_pkg::ADDR_POWER_SAVE;
    wire logic hit_stat = wb_adr_i == psm_pkg::ADDR_STATUS;

    // ==================================================
    // Registers
    // ==================================================
    logic [2:0] ratio_q;
    logic slow_en_q;
    logic recover_q;
    logic core_stby_ctl_q;
    logic flash_stby_ctl_q;
    logic [15:0] pmd_q;
    psm_pkg::psm_state_type state_q;
    psm_pkg::psm_state_type state_d;
    logic sleep_sel_q;
    logic [2:0] resume_cnt_q;
    logic irq_held_q;
    logic ack_q;

    // Next values of the divisor fields
    wire logic div_wr = bus_wr & hit_div;
    wire logic [2:0] ratio_wdata = wb_dat_i[psm_pkg::RATIO_LSB +: 3];
    wire logic en_wdata = wb_dat_i[psm_pkg::SLOWDOWN_EN_BIT];
    // Ratio frozen while enabled, so the live clock never sees a mid-run change
    wire logic ratio_take = div_wr & sel_hi & ~slow_en_q; // [R01]
    wire logic [2:0] ratio_d = ratio_take ? ratio_wdata : ratio_q;
    // Enable refused against the ratio value already stored
    wire logic en_set_ok = en_wdata & (ratio_q != 3'h0); // [R02]
    wire logic irq_recover = recover_q & interrupt_pending; // [R03]
    // Hardware clear wins over a software set in the same cycle
    wire logic slow_en_d = irq_recover ? 1'b0 : ((div_wr & sel_hi) ? en_set_ok : slow_en_q); // [R03]

    // Divisor register
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ratio_q <= psm_pkg::RATIO_RESET;
            slow_en_q <= 1'b0;
            recover_q <= 1'b0;
        end
        else
        begin
            ratio_q <= ratio_d;
            slow_en_q <= slow_en_d;
            if (div_wr & sel_hi)
                recover_q <= wb_dat_i[psm_pkg::RECOVER_BIT];
        end
    end

    // Regulator standby controls, clear by default for lowest Sleep current
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            core_stby_ctl_q <= 1'b0;
            flash_stby_ctl_q <= 1'b0;
        end
        else if (bus_wr & hit_reset_control_reg & sel_hi)
        begin
            core_stby_ctl_q <= wb_dat_i[psm_pkg::CORE_REG_STBY_BIT]; // [R11]
            flash_stby_ctl_q <= wb_dat_i[psm_pkg::FLASH_REG_STBY_BIT]; // [R11]
        end
    end

    // Module disable register, only the channel bits are implemented
    wire logic [15:0] pmd_lanes = {{8{sel_hi}}, {8{sel_lo}}};
    wire logic [15:0] pmd_wmask = pmd_lanes & psm_pkg::MODULE_DISABLE_MASK;
    wire logic [15:0] pmd_d = (pmd_q & ~pmd_wmask) | (wb_dat_i[15:0] & pmd_wmask);
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            pmd_q <= psm_pkg::MODULE_DISABLE_RESET;
        else if (bus_wr & hit_pmd)
            pmd_q <= pmd_d;
    end

    // ==================================================
    // Power-save sequencer
    // ==================================================
    // A write to the power-save word is the instruction; its operand picks the mode
    wire logic instr_issue = bus_wr & hit_pws & sel_lo & (state_q == psm_pkg::PSM_RUN); // [R20]
    wire logic instr_sleep = wb_dat_i[1:0] == psm_pkg::OPERAND_SLEEP;
    wire logic instr_idle = wb_dat_i[1:0] == psm_pkg::OPERAND_IDLE;
    // Reset itself is a wake event through the asynchronous return to run
    wire logic wake_event = interrupt_pending | irq_held_q | wdt_timeout; // [R09] [R14]

    // Next state
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            psm_pkg::PSM_RUN:
                if (instr_issue & (instr_sleep | instr_idle))
                    state_d = psm_pkg::PSM_ENTER;
            psm_pkg::PSM_ENTER:
                state_d = sleep_sel_q ? psm_pkg::PSM_SLEEP : psm_pkg::PSM_IDLE;
            psm_pkg::PSM_SLEEP:
                if (wake_event)
                    state_d = psm_pkg::PSM_RUN; // [R09] [R10]
            psm_pkg::PSM_IDLE:
                if (wake_event)
                    state_d = psm_pkg::PSM_RESUME; // [R14]
            psm_pkg::PSM_RESUME:
                if (resume_cnt_q == 3'h1)
                    state_d = psm_pkg::PSM_RUN; // [R15]
            default:
                state_d = psm_pkg::PSM_RUN;
        endcase
    end

    // State, mode choice, held interrupt and resume counter
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_q <= psm_pkg::PSM_RUN;
            sleep_sel_q <= 1'b0;
            irq_held_q <= 1'b0;
            resume_cnt_q <= 3'h0;
        end
        else
        begin
            state_q <= state_d;
            if (instr_issue)
                sleep_sel_q <= instr_sleep;
            // Interrupt during entry is held, then wakes once settled
            if (state_q == psm_pkg::PSM_ENTER)
                irq_held_q <= irq_held_q | interrupt_pending; // [R17]
            else if (state_q != psm_pkg::PSM_RUN)
                irq_held_q <= 1'b0;
            else
                irq_held_q <= instr_issue & interrupt_pending; // [R17]
            if (state_q == psm_pkg::PSM_IDLE)
                resume_cnt_q <= psm_pkg::IDLE_RESUME_CYCLES; // [R15]
            else if (resume_cnt_q != 3'h0)
                resume_cnt_q <= resume_cnt_q - 3'h1;
        end
    end

    // ==================================================
    // Clock and power outputs
    // ==================================================
    wire logic in_sleep = state_q == psm_pkg::PSM_SLEEP;
    wire logic in_idle = (state_q == psm_pkg::PSM_IDLE) | (state_q == psm_pkg::PSM_RESUME);
    // Clock source selection lives outside; we only gate it, so wake returns to it
    assign power_ctl.sys_clk_run = ~in_sleep; // [R04] [R10] [R12]
    assign power_ctl.onchip_osc_run = ~in_sleep; // [R04]
    assign power_ctl.monitor_active = monitor_enabled & ~in_sleep; // [R05]
    assign power_ctl.low_power_rc_osc_run = in_sleep ? wdt_enabled :
        (in_idle ? (wdt_enabled | monitor_enabled) : 1'b1); // [R06] [R13]
    assign power_ctl.core_reg_standby = in_sleep & ~core_stby_ctl_q; // [R11]
    assign power_ctl.flash_reg_standby = in_sleep & ~flash_stby_ctl_q; // [R11]
    assign power_ctl.cpu_clk_run = state_q == psm_pkg::PSM_RUN; // [R12] [R15]
    assign power_ctl.sysclk_periph_run = ~in_sleep; // [R08]
    // Watchdog cleared in the entry cycle, ahead of either mode
    assign power_ctl.wdt_clear = (state_q == psm_pkg::PSM_ENTER) & wdt_enabled; // [R07] [R12]
    assign cpu_resumed = (state_q == psm_pkg::PSM_RESUME) & (resume_cnt_q == 3'h1); // [R15]

    // Per-peripheral run enables
    genvar gi;
    generate
        for (gi = 0; gi < PERIPH_COUNT; gi++)
        begin : g_periph
            assign periph_run[gi] = ~in_sleep & ~(in_idle & periph_stop_in_idle[gi]); // [R08] [R16]
        end
    endgenerate

    assign capture_off = pmd_q[psm_pkg::CAPTURE_LSB +: 4]; // [R18]
    assign compare_off = pmd_q[psm_pkg::COMPARE_LSB +: 4]; // [R19]
    assign cpu_slowdown_ratio = ratio_q;
    assign slowdown_active = slow_en_q;

    // ==================================================
    // Read mux and acknowledge
    // ==================================================
    wire logic [15:0] div_rd = {recover_q, ratio_q, slow_en_q, 11'h000};
    wire logic [15:0] reset_control_reg_rd = {4'h0, flash_stby_ctl_q, 2'h0, core_stby_ctl_q, 8'h00};
    wire logic [15:0] stat_rd = {12'h000, irq_held_q, in_idle, in_sleep, sleep_sel_q};
    wire logic [15:0] rd_word = hit_div ? div_rd : hit_reset_control_reg ? reset_control_reg_rd : hit_pmd ? pmd_q :
        hit_stat ? stat_rd : 16'h0000;

    // Every address acks in one cycle; unmapped reads return zero
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ack_q <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            ack_q <= bus_req;
            if (bus_req & ~wb_we_i)
                wb_dat_o <= {16'h0000, rd_word};
        end
    end
    assign wb_ack_o = ack_q;

endmodule // psm_power_save_ctl

// >>> testbench/psm_power_save_checker.sv
`timescale 1ns/10ps
// ========
// Power-save checker
module psm_power_save_checker (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic wb_ack_o,
    input wire logic interrupt_pending,
    input wire logic wdt_enabled,
    input wire logic monitor_enabled,
    input wire psm_pkg::psm_power_ctl_type power_ctl,
    input wire logic [2:0] cpu_slowdown_ratio,
    input wire logic slowdown_active,
    input wire logic [3:0] capture_off,
    input wire logic [3:0] compare_off,
    input wire logic cpu_resumed
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Idle proper: the clock was already off a cycle before, so ENTER is excluded
    sequence idle_wait;
        !power_ctl.cpu_clk_run ##1 power_ctl.sys_clk_run && !power_ctl.cpu_clk_run;
    endsequence
    AST_RATIO_LOCK: assert property (slowdown_active |=> $stable(cpu_slowdown_ratio))
        else $error("ratio moved while slowdown on");
    AST_NO_ZERO_EN: assert property ($rose(slowdown_active) |-> $past(cpu_slowdown_ratio) != 3'h0)
        else $error("slowdown enabled with zero ratio");
    AST_SLEEP_GATES: assert property (!power_ctl.sys_clk_run |-> !power_ctl.onchip_osc_run
        && !power_ctl.monitor_active && !power_ctl.sysclk_periph_run && !power_ctl.cpu_clk_run)
        else $error("clock left running in sleep");
    AST_SLEEP_LOW_POWER_RC_OSC: assert property (!power_ctl.sys_clk_run && wdt_enabled |-> power_ctl.low_power_rc_osc_run)
        else $error("rc oscillator off in sleep");
    AST_IDLE_LOW_POWER_RC_OSC: assert property (idle_wait ##0 (wdt_enabled || monitor_enabled) |-> power_ctl.low_power_rc_osc_run)
        else $error("rc oscillator off in idle");
    AST_WDT_CLR: assert property ($fell(power_ctl.sys_clk_run) && wdt_enabled |-> $past(power_ctl.wdt_clear))
        else $error("watchdog not cleared before sleep");
    AST_WAKE: assert property (interrupt_pending && !power_ctl.cpu_clk_run |-> ##[1:6] power_ctl.cpu_clk_run)
        else $error("no wake on interrupt");
    AST_IDLE_RESUME: assert property (idle_wait ##0 interrupt_pending && !cpu_resumed
        |-> ##[2:4] $rose(power_ctl.cpu_clk_run))
        else $error("idle resume late");
    AST_MOD_DIS: assert property ($changed({capture_off, compare_off})
        |-> wb_ack_o && wb_we_i && wb_adr_i == psm_pkg::ADDR_MODULE_DISABLE)
        else $error("disable bits moved without a write");
endmodule // psm_power_save_checker

bind psm_power_save_ctl psm_power_save_checker psm_power_save_checker_i (.clk_sys(clk_sys), .rst(rst),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .interrupt_pending(interrupt_pending),
    .wdt_enabled(wdt_enabled), .monitor_enabled(monitor_enabled), .power_ctl(power_ctl),
    .cpu_slowdown_ratio(cpu_slowdown_ratio), .slowdown_active(slowdown_active),
    .capture_off(capture_off), .compare_off(compare_off), .cpu_resumed(cpu_resumed));

// >>> testbench/psm_core_model.sv
`timescale 1ns/10ps
// ========
// Interrupt source standing in for core and peripherals
module psm_core_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wake_req,
    input wire logic [3:0] dly,
    output logic interrupt_pending
);
    logic [4:0] cnt_q;
    // Two-cycle interrupt starting dly+1 cycles after a sampled request; a short pulse exposes missed wake logic
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= 5'h00;
            interrupt_pending <= 1'h0;
        end
        else
        begin
            cnt_q <= wake_req ? {1'h0, dly} + 5'h02 : cnt_q - {4'h0, cnt_q != 5'h00};
            interrupt_pending <= cnt_q != 5'h00 && cnt_q <= 5'h02;
        end
    end
endmodule // psm_core_model

// >>> testbench/psm_power_save_ctl_tb.sv
`timescale 1ns/10ps
// ========
// Bench
module psm_power_save_ctl_tb;
    logic clk_sys = 1'h0, rst = 1'h1, wb_cyc = 1'h0, wb_stb = 1'h0, wb_we = 1'h0, wb_ack_o;
    logic wdt_timeout = 1'h0, wdt_enabled = 1'h0, monitor_enabled = 1'h0, wake_req = 1'h0, irq;
    logic slow_on, resumed;
    logic [2:0] ratio, r;
    logic [3:0] dly = 4'h1, cap_off, cmp_off, wb_sel = 4'h0;
    logic [7:0] wb_adr = 8'h00, stop = 8'h00, periph_run;
    logic [15:0] v;
    logic [15:0] exp_q[$];
    logic [31:0] wb_dat = 32'h0, wb_dat_o;
    psm_pkg::psm_power_ctl_type pc;
    int bad_count = 0, comparisons = 0;

    always #10 clk_sys = ~clk_sys;
    psm_power_save_ctl psm_power_save_ctl_i (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .interrupt_pending(irq), .wdt_timeout(wdt_timeout),
        .wdt_enabled(wdt_enabled), .monitor_enabled(monitor_enabled), .periph_stop_in_idle(stop),
        .power_ctl(pc), .cpu_slowdown_ratio(ratio), .slowdown_active(slow_on), .periph_run(periph_run),
        .capture_off(cap_off), .compare_off(cmp_off), .cpu_resumed(resumed));
    psm_core_model psm_core_model_i (.clk_sys(clk_sys), .rst(rst), .wake_req(wake_req), .dly(dly),
        .interrupt_pending(irq));

    // ========
    // Tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Classic single cycle; a read notes its expected data first
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
        if (!w)
            exp_q.push_back(d);
        @(posedge clk_sys);
        {wb_cyc, wb_stb, wb_we, wb_sel} <= {1'h1, 1'h1, w, 4'h3};
        {wb_adr, wb_dat} <= {a, 16'h0000, d};
        do @(posedge clk_sys); while (wb_ack_o !== 1'h1);
        {wb_cyc, wb_stb} <= 2'h0;
    endtask
    // Wait for sys (k=0) or cpu (k=1) clock to reach lvl, then one more cycle
    task automatic go(input logic k, input logic lvl);
        do @(posedge clk_sys); while ((k ? pc.cpu_clk_run : pc.sys_clk_run) !== lvl);
        @(posedge clk_sys);
    endtask
    task automatic fire;
        wake_req <= 1'h1;
        @(posedge clk_sys);
        wake_req <= 1'h0;
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Read results are judged in order of issue
    always @(posedge clk_sys)
    begin
        if (wb_ack_o === 1'h1 && wb_we === 1'h0)
            check(wb_dat_o[15:0], exp_q.pop_front());
    end
    // Hang guard, far beyond the whole sequence
    initial
    begin
        #400000;
        bad_count++;
        end_of_test;
    end

    // ========
    // Main sequence
    initial
    begin
        void'($urandom(32'h126E0080));
        repeat (4) @(posedge clk_sys);
        rst <= 1'h0;
        wb(1'h0, psm_pkg::ADDR_MODULE_DISABLE, 16'h0000);
        wb(1'h0, 8'h20, 16'h0000);
        $display("done reset values");
        r = 3'($urandom_range(7, 1));
        wb(1'h1, psm_pkg::ADDR_CLOCK_DIVISOR, 16'h0800);
        wb(1'h0, psm_pkg::ADDR_CLOCK_DIVISOR, 16'h0000);
        wb(1'h1, psm_pkg::ADDR_CLOCK_DIVISOR, {1'h0, r, 12'h000});
        wb(1'h1, psm_pkg::ADDR_CLOCK_DIVISOR, {1'h0, r, 12'h800});
        wb(1'h1, psm_pkg::ADDR_CLOCK_DIVISOR, {1'h0, ~r, 12'h800});
        wb(1'h0, psm_pkg::ADDR_CLOCK_DIVISOR, {1'h0, r, 12'h800});
        check({13'h0000, ratio}, {13'h0000, r});
        $display("done slowdown interlocks");
        wb(1'h1, psm_pkg::ADDR_CLOCK_DIVISOR, {1'h1, r, 12'h800});
        fire;
        repeat (12) @(posedge clk_sys);
        wb(1'h0, psm_pkg::ADDR_CLOCK_DIVISOR, {1'h1, r, 12'h000});
        $display("done recover on interrupt");
        v = 16'($urandom());
        wb(1'h1, psm_pkg::ADDR_MODULE_DISABLE, v);
        wb(1'h0, psm_pkg::ADDR_MODULE_DISABLE, v & psm_pkg::MODULE_DISABLE_MASK);
        check({8'h00, cap_off, cmp_off}, {8'h00, v[11:8], v[3:0]});
        $display("done module disable");
        // Sleep with each regulator choice; woken by interrupt, then by watchdog
        wdt_enabled <= 1'h1;
        dly <= 4'hA;
        for (int k = 0; k < 2; k++)
        begin
            v = k ? 16'h0900 : 16'h0000;
            wb(1'h1, psm_pkg::ADDR_RESET_CONTROL, v);
            wb(1'h1, psm_pkg::ADDR_POWER_SAVE, 16'h0000);
            go(1'h0, 1'h0);
            check({13'h0, pc.core_reg_standby, pc.flash_reg_standby, pc.low_power_rc_osc_run}, {13'h0, ~v[8], ~v[11], 1'h1});
            if (k == 0)
                fire;
            else
                wdt_timeout <= 1'h1;
            go(1'h1, 1'h1);
            wdt_timeout <= 1'h0;
        end
        $display("done sleep");
        {wdt_enabled, monitor_enabled, stop} <= {1'h0, 1'h1, 8'($urandom())};
        wb(1'h1, psm_pkg::ADDR_POWER_SAVE, 16'h0001);
        go(1'h1, 1'h0);
        check({13'h0, pc.sys_clk_run, pc.low_power_rc_osc_run, pc.sysclk_periph_run}, 16'h0007);
        check({8'h00, periph_run}, {8'h00, ~stop});
        fire;
        go(1'h1, 1'h1);
        $display("done idle");
        end_of_test;
    end
endmodule // psm_power_save_ctl_tb
